//--- include/dac_serial_pkg.sv
// Constants and types for the serial word input port of the current-output converter
// Function
// - Each write is one 16-bit word, falling-edge capture until code 11 selects rising
// - Host launches on rise, device samples on fall
// - Frame sync rising edge updates converter register
// - First received bit is the word MSB
// - Read-back shifts old contents out on the clock edge opposite capture
// - Two control bits, 12 data, two ignored
// - Code 00 loads, 11 selects rising capture
// - Data accepted only while frame sync low
// - Reset clears shift register, converter register and mode latch to zero; the core-active flag resets to one
package dac_serial_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int CNT_W = 5;
  localparam int CTRL_HI_POS = 15;
  localparam int CTRL_LO_POS = 14;
  localparam int DATA_MSB_POS = 13;
  localparam int DATA_LSB_POS = 2;
  localparam logic [1:0] CTRL_LOAD = 2'h0;
  localparam logic [1:0] CTRL_RISE = 2'h3;
  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_RST = 12'h000;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

  typedef struct packed {
    logic sclk_fall;
    logic sclk_rise;
    logic sync_fall;
    logic sync_rise;
    logic sync_low;
    logic din;
  } pin_events_t;

  typedef struct packed {
    logic ctrl_bit_high;
    logic ctrl_bit_low;
    logic [DATA_W-1:0] code;
    logic [1:0] ignored;
  } word_t;
endpackage

//--- rtl/dac_pin_sampler.sv
// Two-flop synchronisers and edge detection for the three serial pins
`timescale 1ns/1ps
module dac_pin_sampler (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_serial_din,
  input wire logic i_sync_n,
  output dac_serial_pkg::pin_events_t o_ev
);
  import dac_serial_pkg::*;

  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] prev_ff;

  // Stage 1 is read only by stage 2; the edge detectors look at stages 2 and 3
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_ff <= 3'h1;
      sync_ff <= 3'h1;
      prev_ff <= 3'h1;
    end else begin
      meta_ff <= {i_sclk, i_serial_din, i_sync_n};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign o_ev.sclk_fall = prev_ff[2] & ~sync_ff[2];
  assign o_ev.sclk_rise = ~prev_ff[2] & sync_ff[2];
  assign o_ev.din = sync_ff[1];
  assign o_ev.sync_fall = prev_ff[0] & ~sync_ff[0];
  assign o_ev.sync_rise = ~prev_ff[0] & sync_ff[0];
  assign o_ev.sync_low = ~sync_ff[0];
endmodule

//--- rtl/dac_serial_word_input.sv
// Serial word input port: shift register, control decode, converter register, read-back
`timescale 1ns/1ps
module dac_serial_word_input (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_serial_din,
  input wire logic i_sync_n,
  output logic [dac_serial_pkg::DATA_W-1:0] o_dac_code,
  output logic o_update,
  output logic o_rise_capture,
  output logic o_core_active,
  output logic o_serial_readback_out
);
  import dac_serial_pkg::*;

  // Timing: each pin passes two synchroniser flops and one edge flop, so a pin edge
  // acts three clocks after it arrives; every pin level must stand at least three
  // clocks, which caps the serial clock at a sixth of i_clk. The converter register
  // and its update strobe change on the third clock after sync rises. Bits after
  // the sixteenth of a frame are dropped; the first sixteen are kept.

  // IDLE waits for sync to fall, SHIFT gathers bits until sync rises, DONE lets the
  // frame close for one clock before a new one may open
  typedef enum logic [1:0] {IDLE, SHIFT, DONE} frame_state_t;

  pin_events_t ev;
  frame_state_t state_ff;
  frame_state_t nxt_state;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [DATA_W-1:0] code_ff;
  logic update_ff;
  logic rise_mode_ff;
  logic active_ff;
  logic rb_ff;
  word_t rx_word;
  logic cap_edge;
  logic out_edge;
  logic take_bit;
  logic word_full;
  logic do_load;
  logic do_rise;
  logic in_frame;
  logic [1:0] ctrl_code;
  logic is_load_code;
  logic is_rise_code;
  logic frame_end;
  logic frame_ok;
  logic [WORD_W-1:0] shift_in;
  // Read-back keeps its own copy of the outgoing word
  logic [WORD_W-1:0] rb_word_ff;
  logic [WORD_W-1:0] nxt_rb_word;
  logic rb_snap;
  logic rb_launch;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling; reset holds sync high and clock low, matching the idle pins,
  // so no false edge follows reset
  dac_pin_sampler u_sampler (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sclk(i_sclk),
    .i_serial_din(i_serial_din),
    .i_sync_n(i_sync_n),
    .o_ev(ev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Capture edge selection and bit acceptance
  assign cap_edge = rise_mode_ff ? ev.sclk_rise : ev.sclk_fall;
  assign out_edge = rise_mode_ff ? ev.sclk_fall : ev.sclk_rise;
  assign word_full = (cnt_ff == BITS_PER_WORD);
  // Bits beyond the sixteenth are dropped; clock and data ignored with sync high
  assign in_frame = (state_ff == SHIFT) & ev.sync_low;
  assign take_bit = in_frame & cap_edge & ~word_full & active_ff;
  assign nxt_cnt = ev.sync_fall ? CNT_RST : (take_bit ? cnt_ff + 5'h01 : cnt_ff);

  //////////////////////////////////////////////////////////////////////////////
  // Input shift register: bit 0 takes the pin, each higher bit its lower neighbour,
  // so the first bit of a frame ends up as the word MSB after sixteen captures
  for (genvar b = 0; b < WORD_W; b++) begin : g_shift
    if (b == 0) begin : g_pin
      assign shift_in[b] = ev.din;
    end else begin : g_chain
      assign shift_in[b] = shift_ff[b-1];
    end
    assign nxt_shift[b] = take_bit ? shift_in[b] : shift_ff[b];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control decode of the assembled word
  assign rx_word = word_t'(shift_ff);
  assign ctrl_code = {rx_word.ctrl_bit_high, rx_word.ctrl_bit_low};
  assign is_load_code = (ctrl_code == CTRL_LOAD);
  assign is_rise_code = (ctrl_code == CTRL_RISE);
  // A frame counts only if it closes with sync rising after sixteen captures;
  // reserved codes and short words fall through with no effect
  assign frame_end = ev.sync_rise & (state_ff == SHIFT);
  assign frame_ok = frame_end & word_full & active_ff;
  assign do_load = frame_ok & is_load_code;
  assign do_rise = frame_ok & is_rise_code;

  //////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IDLE: begin
        if (ev.sync_fall) begin
          nxt_state = SHIFT;
        end
      end
      SHIFT: begin
        if (ev.sync_rise) begin
          nxt_state = DONE;
        end
      end
      DONE: begin
        nxt_state = IDLE;
      end
      default: begin
        nxt_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Contents stay put between frames; read-back copies them at the next frame open
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shift_ff <= SHIFT_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // Bit count restarts at every sync fall, so a short frame leaves no debt for the next
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff <= CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Converter register and clock-edge mode latch
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      code_ff <= CODE_RST;
    end else if (do_load) begin
      code_ff <= rx_word.code;
    end
  end

  // One-cycle strobe beside the code so downstream logic can count updates
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      update_ff <= 1'b0;
    end else begin
      update_ff <= do_load;
    end
  end

  // Rising capture persists until reset; only i_srst brings back falling capture
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rise_mode_ff <= 1'b0;
    end else if (do_rise) begin
      rise_mode_ff <= 1'b1;
    end
  end

  // Core sits idle from the mode switch until the next frame opens
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      active_ff <= 1'b1;
    end else if (do_rise) begin
      active_ff <= 1'b0;
    end else if (ev.sync_fall) begin
      active_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back: the word held at frame open is copied aside so that it leaves MSB first
  // on the launch edges, undisturbed by the bits captured in the same frame.
  // In rising capture the launch edge moves to the falling clock.
  assign rb_snap = ev.sync_fall;
  assign rb_launch = ev.sync_low & out_edge & ~ev.sync_fall;
  assign nxt_rb_word = rb_snap ? shift_ff : (rb_launch ? {rb_word_ff[WORD_W-2:0], 1'b0} : rb_word_ff);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rb_word_ff <= SHIFT_RST;
    end else begin
      rb_word_ff <= nxt_rb_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rb_ff <= 1'b0;
    end else if (rb_launch) begin
      rb_ff <= rb_word_ff[WORD_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from its register
  assign o_dac_code = code_ff;
  assign o_update = update_ff;
  assign o_rise_capture = rise_mode_ff;
  assign o_core_active = active_ff;
  assign o_serial_readback_out = rb_ff;
endmodule

//--- test/dac_host_model.sv
// Host serial port model
`timescale 1ns/1ps
module dac_host_model (
  input wire logic i_clk,
  input wire logic i_rb,
  output logic o_sclk = 1'h0,
  output logic o_din = 1'h1,
  output logic o_sync_n = 1'h1,
  output logic [15:0] o_rb = 16'h0
);
  // Sends n bits MSB first; r picks rising capture, b pauses after a byte
  task automatic send(input logic [15:0] w, input int n, input bit r, input bit b);
    o_sync_n = 1'h0;
    repeat (6) @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      if (b && i == 8) repeat (20) @(negedge i_clk);
      o_sclk = !r;
      o_din = w[15-i];
      repeat (6) @(negedge i_clk);
      o_rb = {o_rb[14:0], i_rb};
      o_sclk = r;
      repeat (6) @(negedge i_clk);
    end
    o_sclk = 1'h0;
    o_sync_n = 1'h1;
    o_din = !o_din;
    repeat (8) @(negedge i_clk);
  endtask
  // Toggles clock and data with sync high; the port must ignore all of it
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      o_sclk = !o_sclk;
      o_din = !o_din;
      repeat (6) @(negedge i_clk);
    end
    o_sclk = 1'h0;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

//--- test/dac_serial_word_input_monitor.sv
// Checker for the serial word input port
`timescale 1ns/1ps
module dac_serial_word_input_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_serial_din,
  input wire logic i_sync_n,
  input wire logic [dac_serial_pkg::DATA_W-1:0] o_dac_code,
  input wire logic o_update,
  input wire logic o_rise_capture,
  input wire logic o_core_active,
  input wire logic o_serial_readback_out
);
  import dac_serial_pkg::*;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_upd_pulse: assert property (o_update |=> !o_update) else $error("pulse");
  a_upd_delay: assert property (o_update |-> $past(i_sync_n, 3)) else $error("early");
  a_code_hold: assert property ($changed(o_dac_code) |-> o_update) else $error("code");
  a_rise_sticky: assert property (o_rise_capture |=> o_rise_capture) else $error("rise");
  a_idle_cause: assert property ($fell(o_core_active) |-> o_rise_capture) else $error("idle");
  a_wake_sync: assert property (!o_core_active && $fell(i_sync_n) |-> ##[1:6] o_core_active)
    else $error("wake");
  a_rb_quiet: assert property (i_sync_n [*8] |=> $stable(o_serial_readback_out)) else $error("rb");
  a_rst_value: assert property ($fell(i_srst) |-> o_dac_code == CODE_RST && o_core_active && !o_update)
    else $error("reset");
  c_load: cover property (o_update);
  c_rise: cover property ($rose(o_rise_capture));
  c_wake: cover property ($rose(o_core_active));
endmodule
bind dac_serial_word_input dac_serial_word_input_monitor dac_serial_word_input_monitor_inst (.*);

//--- test/tb_dac_serial_word_input.sv
// Bench for the serial word input port
`timescale 1ns/1ps
module tb_dac_serial_word_input;
  import dac_serial_pkg::*;
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  logic i_sclk, i_serial_din, i_sync_n, o_update, o_rise_capture, o_core_active, o_serial_readback_out;
  logic [DATA_W-1:0] o_dac_code;
  logic [15:0] rbw;
  int err_total = 0;
  int n_tests = 0;
  int n_upd = 0;
  int cyc = 0;
  dac_serial_word_input dac_serial_word_input_inst (.*);
  dac_host_model dac_host_model_inst (.i_clk, .i_rb(o_serial_readback_out), .o_sclk(i_sclk),
    .o_din(i_serial_din), .o_sync_n(i_sync_n), .o_rb(rbw));
  always #4 i_clk = !i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (o_update === 1'h1) n_upd++;
    if (cyc == 4000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic st(input string t, input logic [11:0] c, input logic [1:0] u, input logic r, input logic a);
    chk("state", {c, u, r, a}, {o_dac_code, n_upd[1:0], o_rise_capture, o_core_active});
    $display("%s done", t);
  endtask
  task automatic t_load;
    dac_host_model_inst.send(16'h2AF3, 16, 1'h0, 1'h0);
    st("load", 12'hABC, 2'h1, 1'h0, 1'h1);
  endtask
  task automatic t_bytes;
    dac_host_model_inst.send(16'h1694, 16, 1'h0, 1'h1);
    chk("readback", 16'h2AF3, rbw);
    st("bytes", 12'h5A5, 2'h2, 1'h0, 1'h1);
  endtask
  task automatic t_refuse;
    dac_host_model_inst.send(16'h7FFC, 16, 1'h0, 1'h0);
    dac_host_model_inst.send(16'hBFFC, 16, 1'h0, 1'h0);
    dac_host_model_inst.send(16'h3FFC, 15, 1'h0, 1'h0);
    dac_host_model_inst.idle_clocks(8);
    st("refuse", 12'h5A5, 2'h2, 1'h0, 1'h1);
  endtask
  task automatic t_rise;
    dac_host_model_inst.send(16'hC000, 16, 1'h0, 1'h0);
    chk("readback", 16'h1FFE, rbw);
    st("switch", 12'h5A5, 2'h2, 1'h1, 1'h0);
    dac_host_model_inst.send(16'h3FFC, 16, 1'h1, 1'h0);
    st("rise", 12'hFFF, 2'h3, 1'h1, 1'h1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'h0;
    repeat (4) @(negedge i_clk);
    st("reset", 12'h000, 2'h0, 1'h0, 1'h1);
    t_load();
    t_bytes();
    t_refuse();
    t_rise();
    final_report();
  end
endmodule
